/* common/cap_edge_if.sv */
// Edge events passed from the input synchroniser to the channel core.
`timescale 1ns/1ps
interface cap_edge_if;
	logic rise;
	logic fall;
	modport src (output rise, output fall);
	modport dst (input rise, input fall);
endinterface

/* common/ccp_params.svh */
// Offsets, field positions, reset values and timing counts of the capture/compare channel.
`ifndef CCP_PARAMS_SVH
`define CCP_PARAMS_SVH

`define CCP_CTRL_OFS     8'h00
`define CCP_SRC_OFS      8'h04
`define CCP_VAL_LO_OFS   8'h08
`define CCP_VAL_HI_OFS   8'h0c
`define CCP_STATUS_OFS   8'h10

`define CCP_CTRL_MODE_LSB 0
`define CCP_CTRL_MODE_MSB 3
`define CCP_CTRL_OD_BIT   4
`define CCP_CTRL_TB_BIT   5
`define CCP_SRC_MSB       1
`define CCP_STAT_FLAG_BIT 0
`define CCP_STAT_OUT_BIT  1

`define CCP_CTRL_RST     8'h00
`define CCP_SRC_RST      2'h0
`define CCP_VAL_RST      16'h0000

`define CCP_PSC_DIV4_LAST  4'h3
`define CCP_PSC_DIV16_LAST 4'hf

`endif

/* common/ccp_pkg.sv */
// Types shared by the capture/compare channel modules.
package ccp_pkg;

	// Listing order fixes the mode field codes; zero is the off state.
	typedef enum logic [3:0] {
		MODE_OFF,
		MODE_CMP_TOGGLE_CLR,
		MODE_CMP_TOGGLE,
		MODE_CAP_ANY_EDGE,
		MODE_CAP_FALL,
		MODE_CAP_RISE,
		MODE_CAP_RISE4,
		MODE_CAP_RISE16,
		MODE_CMP_SET,
		MODE_CMP_CLEAR,
		MODE_CMP_PULSE,
		MODE_CMP_PULSE_CLR
	} ccp_mode_t;

endpackage

/* hw/capture_compare_unit.sv */
// Capture/compare channel with an APB register slave.
//
// Function
// - Value held as separate low and high byte registers.
// - Time base A, the odd one, is selected by default.
// - Several channels may share one time base in the same mode group.
// - Compare output may be driven open-drain instead of push-pull.
// - A capture event copies the full 16-bit time base value.
// - Capture on falling, rising, every 4th or 16th rising, or any edge.
// - Every capture sets the flag; only software clears it.
// - A newer capture overwrites an unread value.
// - Capture event source comes from the source select register.
// - With the pin as output, the driven level feeds the capture path.
// - Mode changes may raise a false flag; software clears it afterwards.
// - Prescaler cleared when off, outside capture, and on reset.
// - Changing between capture prescalers keeps the prescaler count.
// - Capture works in sleep with an external time base clock.
// - Compare checks value against the time base every cycle.
// - Match action is toggle, toggle+clear, set, clear, pulse, pulse+clear.
// - Every compare match sets the flag.
// - Modes 0001 and 1011 clear the time base on a match.
// - Writing zero to the control register forces the output latch low.
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "ccp_params.svh"
module capture_compare_unit
	import ccp_pkg::*;
#(
	parameter int TB_W = 16,
	parameter int AW   = 8
) (
	// Clock and reset
	input  wire logic            pclk,
	input  wire logic            presetn,
	// APB slave
	input  wire logic [AW-1:0]   paddr,
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [31:0]     pwdata,
	output logic      [31:0]     prdata,
	output logic                 pready,
	output logic                 pslverr,
	// Time bases
	input  wire logic [TB_W-1:0] time_base_a,
	input  wire logic [TB_W-1:0] time_base_b,
	input  wire logic            time_base_tick,
	input  wire logic            time_base_external,
	output logic                 time_base_clear,
	// Capture sources and pin
	input  wire logic            channel_pin_in,
	input  wire logic            pin_direction_bit,
	input  wire logic            port_latch,
	input  wire logic [2:0]      aux_capture_src,
	input  wire logic            sleep_mode,
	output logic                 channel_pin_out,
	output logic                 channel_pin_oe,
	// Event flag
	output logic                 channel_interrupt_flag
);

	logic [7:0]      channel_control_reg_q;
	logic [1:0]      capture_source_select_reg_q;
	logic [TB_W-1:0] value_q;
	logic            flag_q;
	logic            out_q;
	logic [3:0]      psc_q;
	logic            match_q;
	logic            tclr_q;
	logic            pin_out_q;
	logic            pin_oe_q;
	logic [31:0]     rdata_q;
	logic            ready_q;
	logic            err_q;

	ccp_mode_t       mode;
	logic            open_drain;
	logic [TB_W-1:0] tb_val;
	logic            is_cap;
	logic            is_cmp;
	logic            wr_en;
	logic            cap_level;
	logic            cap_evt;
	logic            cmp_evt;
	logic            match;
	logic            flag_clr;
	logic            ctrl_zero_wr;

	cap_edge_if edges ();

	function automatic logic is_mapped(input logic [AW-1:0] a);
		return a == `CCP_CTRL_OFS || a == `CCP_SRC_OFS || a == `CCP_VAL_LO_OFS ||
			a == `CCP_VAL_HI_OFS || a == `CCP_STATUS_OFS;
	endfunction

	// The enable is an argument so that continuous assignments that call this re-evaluate when it changes.
	function automatic logic is_wr(input logic en, input logic [AW-1:0] a, input logic [AW-1:0] ofs);
		return en && a == ofs;
	endfunction

	assign mode       = ccp_mode_t'(channel_control_reg_q[`CCP_CTRL_MODE_MSB:`CCP_CTRL_MODE_LSB]);
	assign open_drain = channel_control_reg_q[`CCP_CTRL_OD_BIT];
	// Select bit clear picks the odd time base; channels in one mode group may share it.
	assign tb_val     = channel_control_reg_q[`CCP_CTRL_TB_BIT] ? time_base_b : time_base_a;
	assign is_cap     = mode inside {MODE_CAP_ANY_EDGE, MODE_CAP_FALL, MODE_CAP_RISE,
		MODE_CAP_RISE4, MODE_CAP_RISE16};
	assign is_cmp     = mode != MODE_OFF && !is_cap;
	assign wr_en      = psel && penable && ready_q && pwrite;
	assign flag_clr   = is_wr(wr_en, paddr, `CCP_STATUS_OFS) && pwdata[`CCP_STAT_FLAG_BIT];
	assign ctrl_zero_wr = is_wr(wr_en, paddr, `CCP_CTRL_OFS) && pwdata[7:0] == 8'h00;

	// An output pin feeds its own driven level back into the capture path.
	always_comb begin
		case (capture_source_select_reg_q)
		2'd0: cap_level = pin_direction_bit ? channel_pin_in : port_latch;
		2'd1: cap_level = aux_capture_src[0];
		2'd2: cap_level = aux_capture_src[1];
		default: cap_level = aux_capture_src[2];
		endcase
	end

	capture_edge_detect u_edge (
		.pclk     (pclk),
		.presetn  (presetn),
		.level_in (cap_level),
		.edges    (edges.src)
	);

	// Capture keeps running in sleep only while the time base has an external clock.
	always_comb begin
		cap_evt = 1'b0;
		if (!sleep_mode || time_base_external) begin
			case (mode)
			MODE_CAP_ANY_EDGE: cap_evt = edges.rise | edges.fall;
			MODE_CAP_FALL:     cap_evt = edges.fall;
			MODE_CAP_RISE:     cap_evt = edges.rise;
			MODE_CAP_RISE4:    cap_evt = edges.rise && psc_q == `CCP_PSC_DIV4_LAST;
			MODE_CAP_RISE16:   cap_evt = edges.rise && psc_q == `CCP_PSC_DIV16_LAST;
			default:           cap_evt = 1'b0;
			endcase
		end
	end

	// Prescaler counts rising edges; moving between capture modes does not reset it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			psc_q <= 4'h0;
		end else if (!is_cap) begin
			psc_q <= 4'h0;
		end else if (cap_evt) begin
			psc_q <= 4'h0;
		end else if (edges.rise) begin
			psc_q <= psc_q + 4'h1;
		end
	end

	assign match   = is_cmp && tb_val == value_q;
	assign cmp_evt = match && !match_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_q <= 1'b0;
		end else begin
			match_q <= match;
		end
	end

	// Control and source select registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			channel_control_reg_q       <= `CCP_CTRL_RST;
			capture_source_select_reg_q <= `CCP_SRC_RST;
		end else begin
			if (is_wr(wr_en, paddr, `CCP_CTRL_OFS)) begin
				channel_control_reg_q <= pwdata[7:0];
			end
			if (is_wr(wr_en, paddr, `CCP_SRC_OFS)) begin
				capture_source_select_reg_q <= pwdata[`CCP_SRC_MSB:0];
			end
		end
	end

	// A capture beats a software byte write in the same cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			value_q <= `CCP_VAL_RST;
		end else if (cap_evt) begin
			value_q <= tb_val;
		end else begin
			if (is_wr(wr_en, paddr, `CCP_VAL_LO_OFS)) begin
				value_q[7:0] <= pwdata[7:0];
			end
			if (is_wr(wr_en, paddr, `CCP_VAL_HI_OFS)) begin
				value_q[TB_W-1:8] <= pwdata[TB_W-9:0];
			end
		end
	end

	// Set wins over a software clear in the same cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= (flag_q && !flag_clr) || cap_evt || cmp_evt;
		end
	end

	// Compare output latch, kept apart from the port data latch.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_q <= 1'b0;
		end else if (ctrl_zero_wr) begin
			out_q <= 1'b0;
		end else if (cmp_evt) begin
			case (mode)
			MODE_CMP_TOGGLE_CLR, MODE_CMP_TOGGLE: out_q <= !out_q;
			MODE_CMP_SET:                         out_q <= 1'b1;
			MODE_CMP_CLEAR:                       out_q <= 1'b0;
			MODE_CMP_PULSE, MODE_CMP_PULSE_CLR:   out_q <= 1'b1;
			default:                              out_q <= out_q;
			endcase
		end else if (time_base_tick && (mode == MODE_CMP_PULSE || mode == MODE_CMP_PULSE_CLR)) begin
			out_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tclr_q <= 1'b0;
		end else begin
			tclr_q <= cmp_evt && (mode == MODE_CMP_TOGGLE_CLR || mode == MODE_CMP_PULSE_CLR);
		end
	end

	// Pin drive lags the latch by one cycle so that both pin outputs are flops.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_out_q <= 1'b0;
			pin_oe_q  <= 1'b0;
		end else if (!is_cmp) begin
			pin_out_q <= 1'b0;
			pin_oe_q  <= 1'b0;
		end else if (open_drain) begin
			pin_out_q <= 1'b0;
			pin_oe_q  <= !out_q;
		end else begin
			pin_out_q <= out_q;
			pin_oe_q  <= 1'b1;
		end
	end

	// APB answer: data is prepared in the setup cycle, so the access phase takes one cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_q <= 1'b0;
			err_q   <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else if (psel && !penable) begin
			ready_q <= 1'b1;
			err_q   <= !is_mapped(paddr);
			case (paddr)
			`CCP_CTRL_OFS:   rdata_q <= {24'h00_0000, channel_control_reg_q};
			`CCP_SRC_OFS:    rdata_q <= {30'h0000_0000, capture_source_select_reg_q};
			`CCP_VAL_LO_OFS: rdata_q <= {24'h00_0000, value_q[7:0]};
			`CCP_VAL_HI_OFS: rdata_q <= {24'h00_0000, value_q[TB_W-1:8]};
			`CCP_STATUS_OFS: rdata_q <= {30'h0000_0000, out_q, flag_q};
			default:         rdata_q <= 32'h0000_0000;
			endcase
		end else begin
			ready_q <= 1'b0;
			err_q   <= 1'b0;
		end
	end

	assign prdata                 = rdata_q;
	assign pready                 = ready_q;
	assign pslverr                = err_q;
	assign time_base_clear        = tclr_q;
	assign channel_pin_out        = pin_out_q;
	assign channel_pin_oe         = pin_oe_q;
	assign channel_interrupt_flag = flag_q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_cap_flag;
		cap_evt |=> flag_q;
	endproperty
	a_cap_flag: assert property (p_cap_flag) else $error("capture did not set flag");

	property p_flag_hold;
		flag_q && !flag_clr |=> flag_q;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without clear");

	property p_cap_value;
		cap_evt |=> value_q == $past(tb_val);
	endproperty
	a_cap_value: assert property (p_cap_value) else $error("captured value wrong");

	property p_psc_clear;
		!is_cap |=> psc_q == 4'h0;
	endproperty
	a_psc_clear: assert property (p_psc_clear) else $error("prescaler not cleared");

	property p_div4;
		mode == MODE_CAP_RISE4 && edges.rise && psc_q != `CCP_PSC_DIV4_LAST |-> !cap_evt;
	endproperty
	a_div4: assert property (p_div4) else $error("early divide-by-4 capture");

	property p_cmp_flag;
		cmp_evt |=> flag_q;
	endproperty
	a_cmp_flag: assert property (p_cmp_flag) else $error("match did not set flag");

	property p_tclr;
		cmp_evt && (mode == MODE_CMP_TOGGLE_CLR || mode == MODE_CMP_PULSE_CLR) |=> time_base_clear ##1 !time_base_clear;
	endproperty
	a_tclr: assert property (p_tclr) else $error("timer clear pulse wrong");

	property p_toggle;
		cmp_evt && !ctrl_zero_wr && mode == MODE_CMP_TOGGLE |=> out_q != $past(out_q);
	endproperty
	a_toggle: assert property (p_toggle) else $error("toggle failed");

	property p_zero_ctrl;
		ctrl_zero_wr |=> !out_q && mode == MODE_OFF;
	endproperty
	a_zero_ctrl: assert property (p_zero_ctrl) else $error("output latch not forced low");

	property p_pulse;
		cmp_evt && !ctrl_zero_wr && mode == MODE_CMP_PULSE |=> out_q;
	endproperty
	a_pulse: assert property (p_pulse) else $error("pulse not raised");

	property p_od;
		is_cmp && open_drain |=> !channel_pin_out;
	endproperty
	a_od: assert property (p_od) else $error("open-drain drove high");

	c_capture: cover property (cap_evt && mode == MODE_CAP_RISE16);
	c_pulse:   cover property (cmp_evt && mode == MODE_CMP_PULSE_CLR);
	c_race:    cover property (flag_clr && (cap_evt || cmp_evt));

endmodule // capture_compare_unit

/* hw/capture_edge_detect.sv */
// Two-stage synchroniser and edge detector for the capture input.
`timescale 1ns/1ps
module capture_edge_detect (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Raw capture level
	input  wire logic level_in,
	// Edge events
	cap_edge_if.src   edges
);

	logic meta_q;
	logic sync_q;
	logic prev_q;

	// The first stage feeds only the second stage.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			meta_q <= level_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign edges.rise = sync_q & ~prev_q;
	assign edges.fall = ~sync_q & prev_q;

endmodule // capture_edge_detect

/* tb/event_timer_model.sv */
// Behavioural time base with its tick source, standing beside the channel.
`timescale 1ns/1ps
module event_timer_model #(
	parameter int TICK_DIV = 4
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Bench control
	input  wire logic        hold,
	input  wire logic        load,
	input  wire logic [15:0] load_val,
	// Channel side
	input  wire logic        time_base_clear,
	output logic      [15:0] count_q,
	output logic             tick
);
	logic [7:0] div_q;

	// The count advances once every TICK_DIV system clocks, four by default.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) div_q <= 8'h00;
		else if (div_q == 8'(TICK_DIV - 1)) div_q <= 8'h00;
		else div_q <= div_q + 8'h01;
	end

	// Holding freezes the count so a capture sees one known value.
	assign tick = (div_q == 8'(TICK_DIV - 1)) && !hold;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) count_q <= 16'h0000;
		else if (load) count_q <= load_val;
		else if (time_base_clear) count_q <= 16'h0000;
		else if (tick) count_q <= count_q + 16'h0001;
	end
endmodule // event_timer_model

/* tb/tb_top.sv */
// Self-checking bench for the capture/compare channel.
`timescale 1ns/1ps
`include "ccp_params.svh"
module tb_top;
	import ccp_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] tb_val, tb_b, ld_val, r16, r16b;
	logic        tick, tb_clr, hold, load, ev, dir, pin_in, plat, pin_out, pin_oe, flag, od, seen_hi, seen_clr;
	logic        slp, ext;
	logic [2:0]  aux;
	logic [1:0]  src, r2;
	integer      seed = 32'ha1b66136;
	int          fail_count, num_checks, n, k;
	ccp_mode_t   m;
	ccp_mode_t   cmp_list [6] = '{MODE_CMP_TOGGLE_CLR, MODE_CMP_TOGGLE, MODE_CMP_SET,
		MODE_CMP_CLEAR, MODE_CMP_PULSE, MODE_CMP_PULSE_CLR};

	assign tb_b = ~tb_val;
	assign pin_in = (src == 2'd0 && dir) ? ev : 1'b0;
	assign plat = (src == 2'd0 && !dir) ? ev : 1'b0;
	assign aux = (src == 2'd0) ? 3'h0 : 3'({2'h0, ev} << (src - 2'd1));

	capture_compare_unit uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.time_base_a(tb_val), .time_base_b(tb_b), .time_base_tick(tick), .time_base_external(ext),
		.time_base_clear(tb_clr), .channel_pin_in(pin_in), .pin_direction_bit(dir), .port_latch(plat),
		.aux_capture_src(aux), .sleep_mode(slp), .channel_pin_out(pin_out), .channel_pin_oe(pin_oe),
		.channel_interrupt_flag(flag));

	event_timer_model tmr (.pclk(pclk), .presetn(presetn), .hold(hold), .load(load), .load_val(ld_val),
		.time_base_clear(tb_clr), .count_q(tb_val), .tick(tick));

	always #4 pclk = ~pclk;

	// An open-drain pad reads as high when it lets go of the line.
	always @(posedge pclk) begin
		if ((od ? !pin_oe : pin_out) === 1'b1) seen_hi <= 1'b1;
		if (tb_clr === 1'b1) seen_clr <= 1'b1;
	end

	function automatic logic exp_clr(ccp_mode_t md);
		return md == MODE_CMP_TOGGLE_CLR || md == MODE_CMP_PULSE_CLR;
	endfunction

	function automatic logic exp_lat(ccp_mode_t md);
		return md == MODE_CMP_TOGGLE_CLR || md == MODE_CMP_TOGGLE || md == MODE_CMP_SET;
	endfunction

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 20) begin
			chk("pready", 1, 0);
			give_verdict();
		end
	endtask

	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(what, exp, rd);
	endtask

	task automatic step(input logic lv);
		@(posedge pclk);
		ev <= lv;
		repeat (6) @(posedge pclk);
	endtask

	task automatic set_timer(input logic [15:0] val);
		@(posedge pclk);
		load <= 1'b1;
		ld_val <= val;
		@(posedge pclk);
		load <= 1'b0;
	endtask

	initial begin
		presetn = 1'b0;
		pclk = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{load, ld_val, ev, src, od, seen_hi, seen_clr, slp, ext} = '0;
		hold = 1'b1;
		dir = 1'b1;
		fail_count = 0;
		num_checks = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		for (n = 0; n < 5; n++) rdchk("reset value", 8'(n * 4), 32'h0000_0000);
		apb(1'b1, 8'h14, 32'hffff_ffff);
		chk("unmapped error", 32'h1, {31'h0, err});
		rdchk("unmapped read", 8'h14, 32'h0000_0000);
		r16 = 16'($random(seed));
		apb(1'b1, `CCP_VAL_LO_OFS, {16'h0, r16});
		apb(1'b1, `CCP_VAL_HI_OFS, {24'h0, r16[15:8]});
		rdchk("value low", `CCP_VAL_LO_OFS, {24'h0, r16[7:0]});
		rdchk("value high", `CCP_VAL_HI_OFS, {24'h0, r16[15:8]});
		// Capture: every edge mode, random source and pin direction.
		for (n = 0; n < 10; n++) begin
			m = ccp_mode_t'(3 + n % 5);
			apb(1'b1, `CCP_CTRL_OFS, 32'h0000_0000);
			apb(1'b1, `CCP_STATUS_OFS, 32'h0000_0001);
			r2 = 2'($random(seed));
			src <= r2;
			dir <= 1'($random(seed));
			apb(1'b1, `CCP_SRC_OFS, {30'h0, r2});
			r16 = 16'($random(seed));
			set_timer(r16);
			apb(1'b1, `CCP_CTRL_OFS, {28'h0, m});
			k = (m == MODE_CAP_RISE4) ? 3 : (m == MODE_CAP_RISE16) ? 15 : 0;
			repeat (k) begin
				step(1'b1);
				step(1'b0);
			end
			rdchk("flag before last edge", `CCP_STATUS_OFS, 32'h0);
			step(1'b1);
			rdchk("flag after rise", `CCP_STATUS_OFS, {31'h0, m != MODE_CAP_FALL});
			r16b = 16'($random(seed));
			set_timer(r16b);
			step(1'b0);
			rdchk("flag after fall", `CCP_STATUS_OFS, 32'h1);
			if (m == MODE_CAP_ANY_EDGE || m == MODE_CAP_FALL) r16 = r16b;
			rdchk("captured low", `CCP_VAL_LO_OFS, {24'h0, r16[7:0]});
			rdchk("captured high", `CCP_VAL_HI_OFS, {24'h0, r16[15:8]});
		end
		// Sleep blocks capture unless the time base is externally clocked; bit 5 picks the other base.
		apb(1'b1, `CCP_CTRL_OFS, 32'h0000_0000);
		apb(1'b1, `CCP_STATUS_OFS, 32'h0000_0001);
		src <= 2'd1;
		apb(1'b1, `CCP_SRC_OFS, 32'h0000_0001);
		apb(1'b1, `CCP_CTRL_OFS, 32'h0000_0025);
		slp <= 1'b1;
		step(1'b1);
		step(1'b0);
		rdchk("flag in sleep", `CCP_STATUS_OFS, 32'h0);
		ext <= 1'b1;
		step(1'b1);
		rdchk("flag with external clock", `CCP_STATUS_OFS, 32'h1);
		rdchk("other base low", `CCP_VAL_LO_OFS, {24'h0, ~r16b[7:0]});
		slp <= 1'b0;
		ext <= 1'b0;
		step(1'b0);
		// Compare: every action, random drive style.
		dir <= 1'b0;
		src <= 2'd1;
		for (n = 0; n < 6; n++) begin
			m = cmp_list[n];
			apb(1'b1, `CCP_CTRL_OFS, 32'h0000_0000);
			apb(1'b1, `CCP_STATUS_OFS, 32'h0000_0001);
			rdchk("status after off", `CCP_STATUS_OFS, 32'h0);
			r16 = {11'h0, 5'($random(seed))} + 16'd8;
			apb(1'b1, `CCP_VAL_LO_OFS, {24'h0, r16[7:0]});
			apb(1'b1, `CCP_VAL_HI_OFS, {24'h0, r16[15:8]});
			od <= 1'($random(seed));
			seen_clr <= 1'b0;
			set_timer(16'h0000);
			hold <= 1'b0;
			apb(1'b1, `CCP_CTRL_OFS, {27'h0, od, m});
			// A released open-drain pin reads high until the pin drive follows the new mode.
			repeat (2) @(posedge pclk);
			seen_hi <= 1'b0;
			for (k = 0; k < 400 && flag !== 1'b1; k++) @(posedge pclk);
			chk("compare flag", 32'h1, {31'h0, flag});
			if (flag !== 1'b1) give_verdict();
			repeat (12) @(posedge pclk);
			chk("timer clear", {31'h0, exp_clr(m)}, {31'h0, seen_clr});
			chk("output high", {31'h0, m != MODE_CMP_CLEAR}, {31'h0, seen_hi});
			rdchk("latch", `CCP_STATUS_OFS, {30'h0, exp_lat(m), 1'b1});
			hold <= 1'b1;
		end
		give_verdict();
	end
endmodule // tb_top
